//--- hdl/stpseq_top.sv
// Phase sequencer for a unipolar two-phase stepping motor
`timescale 1ns/1ps
`default_nettype none
`include "stpseq_regs.svh"

// Contract
// - Each rising step clock edge advances the drive pattern by exactly one step.
// - Excitation select is sampled on the step edge, low full-step and high half-step.
// - Direction select low steps forward and high steps in reverse.
// - While the reset pin is low the sequencer is held and all four outputs are off.
// - After reset release the pattern is first winding forward plus second winding reverse.
// - Every control input reads high when left open.
// - In half-step mode each winding is undriven a quarter of the sequence.
module stpseq_top (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Host control pins, pull-up resolved
   input  wire logic step_clock,
   input  wire logic step_clock_oe_n,
   input  wire logic excitation_select,
   input  wire logic excitation_select_oe_n,
   input  wire logic direction_select,
   input  wire logic direction_select_oe_n,
   input  wire logic system_reset_low,
   input  wire logic system_reset_low_oe_n,
   // Winding drive outputs
   output var  logic first_winding_fwd,
   output var  logic first_winding_rev,
   output var  logic second_winding_fwd,
   output var  logic second_winding_rev
);

   stpseq_pkg::stpseq_ctrl_type pins;
   stpseq_pkg::stpseq_ctrl_type ctrl;
   stpseq_pkg::stpseq_state_type state;
   stpseq_pkg::stpseq_drive_type drive;
   stpseq_pkg::stpseq_drive_type next_drive;
   logic                         step_prev;
   logic                         step_rise;
   logic [2:0]                   index;
   logic [2:0]                   next_index;

   // An undriven pin reads high through the pull-up
   always_comb begin
      pins.step_clock       = step_clock_oe_n ? 1'b1 : step_clock;
      pins.half_step        = excitation_select_oe_n ? 1'b1 : excitation_select;
      pins.direction_select = direction_select_oe_n ? 1'b1 : direction_select;
      pins.system_reset_low = system_reset_low_oe_n ? 1'b1 : system_reset_low;
   end

   // Pins are asynchronous to clk
   stpseq_sync u_sync (
      .clk      (clk),
      .rst_n    (rst_n),
      .pin_in   (pins),
      .sync_out (ctrl)
   );

   // Edge detect on the synchronised step clock only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         step_prev <= 1'b1;
      end else begin
         step_prev <= ctrl.step_clock;
      end
   end

   // Held while the reset pin is low, a step clock that is high at release is not an edge
   assign step_rise = ctrl.step_clock & ~step_prev & (state == stpseq_pkg::STPSEQ_RUN);

   // Sequencer state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= stpseq_pkg::STPSEQ_HELD;
      end else begin
         case (state)
            stpseq_pkg::STPSEQ_HELD: begin
               if (ctrl.system_reset_low) begin
                  state <= stpseq_pkg::STPSEQ_RUN;
               end
            end
            stpseq_pkg::STPSEQ_RUN: begin
               if (!ctrl.system_reset_low) begin
                  state <= stpseq_pkg::STPSEQ_HELD;
               end
            end
            default: begin
               state <= stpseq_pkg::STPSEQ_HELD;
            end
         endcase
      end
   end

   // Position on the eight-entry half-step wheel; odd entries are two-winding states
   always_comb begin
      next_index = index;
      if (step_rise) begin
         if (!ctrl.half_step) begin
            // Full step: land on the next odd entry, which also rejoins from a half state
            if (!ctrl.direction_select) begin
               next_index = index[0] ? 3'(index + 3'h2) : 3'(index + 3'h1);
            end else begin
               next_index = index[0] ? 3'(index - 3'h2) : 3'(index - 3'h1);
            end
         end else begin
            next_index = ctrl.direction_select ? 3'(index - 3'h1)
                                               : 3'(index + 3'h1);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         index <= `STPSEQ_INIT_INDEX;
      end else if (state != stpseq_pkg::STPSEQ_RUN) begin
         index <= `STPSEQ_INIT_INDEX;
      end else begin
         index <= next_index;
      end
   end

   // Decode: each winding on for six of eight half steps, off for two (a quarter)
   always_comb begin
      next_drive = `STPSEQ_DRIVE_OFF;
      if (state == stpseq_pkg::STPSEQ_RUN && ctrl.system_reset_low) begin
         case (next_index)
            3'h0: next_drive = 4'h1;  // First fwd
            3'h1: next_drive = 4'h5;  // First fwd, second fwd
            3'h2: next_drive = 4'h4;  // Second fwd
            3'h3: next_drive = 4'h6;  // Second fwd, first rev
            3'h4: next_drive = 4'h2;  // First rev
            3'h5: next_drive = 4'hA;  // First rev, second rev
            3'h6: next_drive = 4'h8;  // Second rev
            3'h7: next_drive = 4'h9;  // Second rev, first fwd
            default: next_drive = `STPSEQ_DRIVE_OFF;
         endcase
      end
   end

   // Outputs registered; cut off while held in reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         drive <= `STPSEQ_DRIVE_OFF;
      end else begin
         drive <= next_drive;
      end
   end

   assign first_winding_fwd  = drive.first_winding_fwd;
   assign first_winding_rev  = drive.first_winding_rev;
   assign second_winding_fwd = drive.second_winding_fwd;
   assign second_winding_rev = drive.second_winding_rev;

   // Helpers for the checks
   logic [1:0] drive_count;
   assign drive_count = 2'(drive[0]) + 2'(drive[1]) + 2'(drive[2]) + 2'(drive[3]);

   a_reset_cuts_off: assert property (@(posedge clk) disable iff (!rst_n)
      !ctrl.system_reset_low |=> (drive == `STPSEQ_DRIVE_OFF))
      else $error("outputs driven while reset pin low");

   // Pin low passes two flops and the output register, so off by the third edge
   a_pin_cuts_off: assert property (@(posedge clk) disable iff (!rst_n)
      !pins.system_reset_low |-> ##3 (drive == `STPSEQ_DRIVE_OFF))
      else $error("outputs driven after reset pin went low");

   a_held_off: assert property (@(posedge clk) disable iff (!rst_n)
      state != stpseq_pkg::STPSEQ_RUN |=> (drive == `STPSEQ_DRIVE_OFF))
      else $error("outputs driven while sequencer held");

   a_held_index: assert property (@(posedge clk) disable iff (!rst_n)
      state != stpseq_pkg::STPSEQ_RUN |=> (index == `STPSEQ_INIT_INDEX))
      else $error("held sequencer lost its start position");

   sequence s_release;
      state == stpseq_pkg::STPSEQ_HELD ##1 state == stpseq_pkg::STPSEQ_RUN;
   endsequence

   a_initial_pattern: assert property (@(posedge clk) disable iff (!rst_n)
      s_release ##0 (!step_rise && ctrl.system_reset_low) |=> (drive == 4'h9))
      else $error("initial pattern wrong after release");

   a_step_moves: assert property (@(posedge clk) disable iff (!rst_n)
      step_rise && ctrl.system_reset_low |=> (index != $past(index)))
      else $error("step edge did not advance");

   a_idle_holds: assert property (@(posedge clk) disable iff (!rst_n)
      !step_rise && state == stpseq_pkg::STPSEQ_RUN |=> $stable(index))
      else $error("pattern moved without a step edge");

   // A full step taken while running and released
   sequence s_full_step;
      step_rise && !ctrl.half_step && ctrl.system_reset_low;
   endsequence

   a_full_two_phase: assert property (@(posedge clk) disable iff (!rst_n)
      s_full_step |=> drive_count == 2'h2)
      else $error("full step gave single phase");

   a_full_lands_odd: assert property (@(posedge clk) disable iff (!rst_n)
      s_full_step |=> index[0])
      else $error("full step left a single-winding state");

   a_half_alternates: assert property (@(posedge clk) disable iff (!rst_n)
      step_rise && ctrl.half_step && ctrl.system_reset_low
      |=> index[0] != $past(index[0]))
      else $error("half step did not alternate");

   a_forward_dir: assert property (@(posedge clk) disable iff (!rst_n)
      step_rise && ctrl.half_step && !ctrl.direction_select && ctrl.system_reset_low
      |=> index == 3'($past(index) + 3'h1))
      else $error("forward step went wrong way");

   a_reverse_dir: assert property (@(posedge clk) disable iff (!rst_n)
      step_rise && ctrl.half_step && ctrl.direction_select && ctrl.system_reset_low
      |=> index == 3'($past(index) - 3'h1))
      else $error("reverse step went wrong way");

   // Index and drive load together, so the landed index names the driven pattern
   a_half_single: assert property (@(posedge clk) disable iff (!rst_n)
      state == stpseq_pkg::STPSEQ_RUN && ctrl.system_reset_low ##1 !index[0]
      |-> drive_count == 2'h1)
      else $error("half state drives two windings");

endmodule

`default_nettype wire

//--- hdl/stpseq_regs.svh
// Constants for the stepper phase sequencer
`ifndef STPSEQ_REGS_SVH
`define STPSEQ_REGS_SVH

// Drive pattern bit positions {second_rev, second_fwd, first_rev, first_fwd}
`define STPSEQ_BIT_FIRST_FWD  0
`define STPSEQ_BIT_FIRST_REV  1
`define STPSEQ_BIT_SECOND_FWD 2
`define STPSEQ_BIT_SECOND_REV 3

// Outputs cut off during reset
`define STPSEQ_DRIVE_OFF      4'h0
// Synchroniser reset: reset pin seen asserted, other pins at their pull-up level
`define STPSEQ_CTRL_RESET     4'hE
// Half-step index of the initial pattern (first fwd + second rev)
`define STPSEQ_INIT_INDEX     3'h7
// Step clock least pulse width and reset hold, in ns
`define STPSEQ_MIN_PULSE_NS   20000
`define STPSEQ_CLK_PERIOD_NS  10
`define STPSEQ_MIN_PULSE_CYC  ((`STPSEQ_MIN_PULSE_NS + `STPSEQ_CLK_PERIOD_NS - 1) / `STPSEQ_CLK_PERIOD_NS)

`endif

//--- hdl/stpseq_pkg.sv
// Types of the stepper phase sequencer
package stpseq_pkg;

   // Winding drive outputs
   typedef struct packed {
      logic second_winding_rev;
      logic second_winding_fwd;
      logic first_winding_rev;
      logic first_winding_fwd;
   } stpseq_drive_type;

   // Control inputs as seen by the sequencer
   typedef struct packed {
      logic step_clock;
      logic half_step;
      logic direction_select;
      logic system_reset_low;
   } stpseq_ctrl_type;

   typedef enum logic [1:0] {
      STPSEQ_HELD,
      STPSEQ_RUN
   } stpseq_state_type;

endpackage

//--- hdl/stpseq_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
`include "stpseq_regs.svh"

module stpseq_sync (
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   // Pin side and synchronised side
   input  wire stpseq_pkg::stpseq_ctrl_type pin_in,
   output var  stpseq_pkg::stpseq_ctrl_type sync_out
);

   stpseq_pkg::stpseq_ctrl_type meta;

   // Reset pin starts as asserted, so no pattern shows before the real pin level arrives
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta     <= `STPSEQ_CTRL_RESET;
         sync_out <= `STPSEQ_CTRL_RESET;
      end else begin
         meta     <= pin_in;
         sync_out <= meta;
      end
   end

endmodule

`default_nettype wire

//--- bench/stpseq_host.sv
// Host controller model that drives the sequencer control pins
`timescale 1ns/1ps
`default_nettype none

module stpseq_host #(
   parameter int PULSE_CYC = 2000
) (
   // Clock
   input  wire logic clk,
   // Control pins with their open flags
   output var  logic step_clock,
   output var  logic step_clock_oe_n,
   output var  logic excitation_select,
   output var  logic excitation_select_oe_n,
   output var  logic direction_select,
   output var  logic direction_select_oe_n,
   output var  logic system_reset_low,
   output var  logic system_reset_low_oe_n
);
   // Power up with the step clock low and the reset pin asserted
   initial begin
      step_clock = 1'b0;
      step_clock_oe_n = 1'b0;
      excitation_select = 1'b0;
      excitation_select_oe_n = 1'b0;
      direction_select = 1'b0;
      direction_select_oe_n = 1'b0;
      system_reset_low = 1'b0;
      system_reset_low_oe_n = 1'b0;
   end

   // An open pin floats to the pull-up level, never to a stale value
   task automatic set_ctrl(input logic mode, input logic dir, input logic open);
      @(posedge clk);
      excitation_select <= open | mode;
      excitation_select_oe_n <= open;
      direction_select <= open | dir;
      direction_select_oe_n <= open;
      repeat (4) @(posedge clk);
   endtask

   // One step, each phase held the least legal width
   task automatic step();
      @(posedge clk);
      step_clock <= 1'b1;
      repeat (PULSE_CYC) @(posedge clk);
      step_clock <= 1'b0;
      repeat (PULSE_CYC) @(posedge clk);
   endtask

   // Leaves the reset pin open with a low level behind it; the pull-up must win
   task automatic open_reset();
      @(posedge clk);
      system_reset_low <= 1'b0;
      system_reset_low_oe_n <= 1'b1;
      repeat (4) @(posedge clk);
   endtask

   // Leaves the low step pin open; the pull-up turns that into a rising edge
   task automatic open_step();
      @(posedge clk);
      step_clock_oe_n <= 1'b1;
      repeat (PULSE_CYC) @(posedge clk);
   endtask

   // Sets the reset pin and holds it the least width
   task automatic pin_reset(input logic level);
      @(posedge clk);
      system_reset_low <= level;
      repeat (PULSE_CYC) @(posedge clk);
   endtask
endmodule

`default_nettype wire

//--- bench/test_stpseq_top.sv
// Self-checking bench of the stepper phase sequencer
`timescale 1ns/1ps
`default_nettype none

module test_stpseq_top;
   // Clock, reset, pins and bookkeeping
   logic                        clk;
   logic                        rst_n;
   logic                        stp, stp_oe_n, mode, mode_oe_n;
   logic                        dir, dir_oe_n, prst, prst_oe_n;
   wire stpseq_pkg::stpseq_drive_type drv;
   int                          mismatches = 0;
   int                          total_checks = 0;
   int                          cycles = 0;
   int                          idx = 7;
   // Drive codes by half-step index
   localparam logic [3:0] PAT [8] = '{4'h1, 4'h5, 4'h4, 4'h6, 4'h2, 4'hA, 4'h8, 4'h9};

   stpseq_host host (.clk(clk), .step_clock(stp), .step_clock_oe_n(stp_oe_n),
      .excitation_select(mode), .excitation_select_oe_n(mode_oe_n),
      .direction_select(dir), .direction_select_oe_n(dir_oe_n),
      .system_reset_low(prst), .system_reset_low_oe_n(prst_oe_n));

   stpseq_top dut (.clk(clk), .rst_n(rst_n), .step_clock(stp), .step_clock_oe_n(stp_oe_n),
      .excitation_select(mode), .excitation_select_oe_n(mode_oe_n),
      .direction_select(dir), .direction_select_oe_n(dir_oe_n),
      .system_reset_low(prst), .system_reset_low_oe_n(prst_oe_n),
      .first_winding_fwd(drv.first_winding_fwd), .first_winding_rev(drv.first_winding_rev),
      .second_winding_fwd(drv.second_winding_fwd),
      .second_winding_rev(drv.second_winding_rev));

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic end_sim();
      $display("Checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Ceiling above the roughly 90k cycles the scenarios need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 95000) begin
         mismatches++;
         end_sim();
      end
   end

   task automatic check(input logic [3:0] exp);
      total_checks++;
      if (drv !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, drv, exp);
      end
   endtask

   // Steps n times; full step skips single-winding states, or leaves one for its neighbour
   task automatic walk(input logic m, input logic d, input int n);
      host.set_ctrl(m, d, 1'b0);
      for (int i = 0; i < n; i++) begin
         host.step();
         idx = (idx + (d ? -1 : 1) * ((m || !idx[0]) ? 1 : 2)) & 7;
         check(PAT[idx]);
      end
   endtask

   task automatic t_reset();
      host.pin_reset(1'b0);
      check(4'h0);
      host.pin_reset(1'b1);
      check(4'h9);
      idx = 7;
   endtask

   // Edges while the reset pin is low must not step
   task automatic t_mid_reset();
      host.pin_reset(1'b0);
      check(4'h0);
      host.step();
      check(4'h0);
      host.pin_reset(1'b1);
      idx = 7;
      check(PAT[idx]);
   endtask

   // Open pins read high: half step, reverse, reset released, step pin rising
   task automatic t_open_pins();
      host.set_ctrl(1'b0, 1'b0, 1'b1);
      host.open_reset();
      host.step();
      check(4'h8);
      host.open_step();
      check(4'hA);
   endtask

   initial begin
      rst_n = 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      walk(1'b0, 1'b0, 4);
      walk(1'b1, 1'b0, 8);
      walk(1'b0, 1'b1, 2);
      walk(1'b1, 1'b1, 3);
      walk(1'b0, 1'b1, 1);
      t_mid_reset();
      t_open_pins();
      end_sim();
   end
endmodule

`default_nettype wire
